// ==== fifo_ctrl_defs.svh ====
`ifndef FIFO_CTRL_DEFS_SVH
`define FIFO_CTRL_DEFS_SVH

`define FCR_WIDTH 16
`define FCR_RESET 16'h0000
`define FCR_RSVD_HI 15
`define FCR_RSVD_LO 11
`define FCR_REQ_HI 10
`define FCR_REQ_LO 8
`define FCR_TRIG_HI 7
`define FCR_TRIG_LO 6
`define FCR_MCE_BIT 3
`define FCR_RW_MASK_FULL 16'h07FF
`define FCR_RW_MASK_NOFLOW 16'h00F7
`define RX_COUNT_WIDTH 5

`define REQ_THR_000 5'h0F
`define REQ_THR_001 5'h01
`define REQ_THR_010 5'h04
`define REQ_THR_011 5'h06
`define REQ_THR_100 5'h08
`define REQ_THR_101 5'h0A
`define REQ_THR_110 5'h0C
`define REQ_THR_111 5'h0E

`define TRIG_ASYNC_00 5'h01
`define TRIG_ASYNC_01 5'h04
`define TRIG_ASYNC_10 5'h08
`define TRIG_ASYNC_11 5'h0E
`define TRIG_SYNC_00 5'h01
`define TRIG_SYNC_01 5'h02
`define TRIG_SYNC_10 5'h08
`define TRIG_SYNC_11 5'h0E

`endif

// ==== fifo_ctrl_pkg.sv ====
`include "fifo_ctrl_defs.svh"

package fifo_ctrl_pkg;

  typedef struct packed {
    logic [4:0] reserved;
    logic [2:0] req_threshold;
    logic [1:0] rx_trigger;
    logic [1:0] tx_trigger;
    logic modem_ctrl_enable;
    logic tx_fifo_reset;
    logic rx_fifo_reset;
    logic loopback;
  } fifo_control_reg_type;

  typedef struct packed {
    logic wr_en;
    logic [15:0] wdata;
  } reg_wr_type;

  typedef struct packed {
    logic [4:0] count;
    logic sync_mode;
    logic rx_full_clear;
  } rx_status_type;

  typedef struct packed {
    fifo_control_reg_type ctrl;
    logic rx_full_flag;
    logic flow_req;
  } state_type;

endpackage : fifo_ctrl_pkg

// ==== fifo_threshold_ctrl.sv ====
// Behaviour
// - 16-bit control register, cleared on reset.
// - register readable and writable at every cycle.
// - bits 15..11 read zero, software writes zero.
// - flow request high when count exceeds threshold; never on third channel.
// - threshold codes: 15,1,4,6,8,10,12,14.
// - third channel: threshold bits reserved, read zero.
// - receive-full flag set when count exceeds trigger.
// - trigger 1,4,8,14 async; 1,2,8,14 sync.
// - modem enable clear holds flow request low.
`timescale 1ns/10ps
`default_nettype none
`include "fifo_ctrl_defs.svh"

module fifo_threshold_ctrl #(
  parameter bit HAS_FLOW_CTRL = 1'b1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire fifo_ctrl_pkg::reg_wr_type reg_wr_i,
  input wire fifo_ctrl_pkg::rx_status_type rx_status_i,
  output logic [15:0] reg_rdata_o,
  output logic rx_full_flag_o,
  output logic flow_req_o
);
  import fifo_ctrl_pkg::*;

  // bits with a flip-flop behind them; the rest are tied off and read zero
  localparam logic [15:0] RW_MASK = HAS_FLOW_CTRL ? `FCR_RW_MASK_FULL : `FCR_RW_MASK_NOFLOW;

  // flow-request threshold in bytes held
  function automatic logic [4:0] req_level(input logic [2:0] code);
    logic [4:0] level;
    level = `REQ_THR_000;
    unique case (code)
      3'h0: begin
        level = `REQ_THR_000;
      end
      3'h1: begin
        level = `REQ_THR_001;
      end
      3'h2: begin
        level = `REQ_THR_010;
      end
      3'h3: begin
        level = `REQ_THR_011;
      end
      3'h4: begin
        level = `REQ_THR_100;
      end
      3'h5: begin
        level = `REQ_THR_101;
      end
      3'h6: begin
        level = `REQ_THR_110;
      end
      3'h7: begin
        level = `REQ_THR_111;
      end
    endcase
    req_level = level;
  endfunction : req_level

  function automatic logic [4:0] trig_async(input logic [1:0] code);
    logic [4:0] level;
    level = `TRIG_ASYNC_00;
    unique case (code)
      2'h0: begin
        level = `TRIG_ASYNC_00;
      end
      2'h1: begin
        level = `TRIG_ASYNC_01;
      end
      2'h2: begin
        level = `TRIG_ASYNC_10;
      end
      2'h3: begin
        level = `TRIG_ASYNC_11;
      end
    endcase
    trig_async = level;
  endfunction : trig_async

  function automatic logic [4:0] trig_sync(input logic [1:0] code);
    logic [4:0] level;
    level = `TRIG_SYNC_00;
    unique case (code)
      2'h0: begin
        level = `TRIG_SYNC_00;
      end
      2'h1: begin
        level = `TRIG_SYNC_01;
      end
      2'h2: begin
        level = `TRIG_SYNC_10;
      end
      2'h3: begin
        level = `TRIG_SYNC_11;
      end
    endcase
    trig_sync = level;
  endfunction : trig_sync

  // the mode input picks the table live; a mode change acts at once
  function automatic logic [4:0] trig_level(input logic [1:0] code, input logic sync_mode);
    logic [4:0] level;
    if (sync_mode) begin
      level = trig_sync(code);
    end else begin
      level = trig_async(code);
    end
    trig_level = level;
  endfunction : trig_level

  state_type state;
  state_type next_state;
  logic [15:0] write_value;
  logic [15:0] masked_wdata;
  fifo_control_reg_type written;
  fifo_control_reg_type next_ctrl;
  fifo_control_reg_type ctrl_now;
  logic [4:0] rx_count;
  logic [4:0] req_limit;
  logic [4:0] trig_limit;
  logic over_req;
  logic over_trig;
  logic flow_allowed;
  logic full_set;
  logic full_clear;

  assign write_value = reg_wr_i.wdata;

  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < `FCR_WIDTH; bit_idx = bit_idx + 1) begin : g_mask
      if (RW_MASK[bit_idx]) begin : g_keep
        assign masked_wdata[bit_idx] = write_value[bit_idx];
      end else begin : g_drop
        assign masked_wdata[bit_idx] = 1'b0;
      end
    end
  endgenerate

  // field by field from the masked data, so a reserved field never picks up write data
  always_comb begin
    written = fifo_control_reg_type'(masked_wdata);
    next_ctrl = state.ctrl;
    if (reg_wr_i.wr_en) begin
      next_ctrl.reserved = written.reserved;
      next_ctrl.req_threshold = written.req_threshold;
      next_ctrl.rx_trigger = written.rx_trigger;
      next_ctrl.tx_trigger = written.tx_trigger;
      next_ctrl.modem_ctrl_enable = written.modem_ctrl_enable;
      next_ctrl.tx_fifo_reset = written.tx_fifo_reset;
      next_ctrl.rx_fifo_reset = written.rx_fifo_reset;
      next_ctrl.loopback = written.loopback;
    end
  end

  // compare uses the stored register, so a write acts from the next cycle
  always_comb begin
    ctrl_now = state.ctrl;
    rx_count = rx_status_i.count;
    req_limit = req_level(ctrl_now.req_threshold);
    trig_limit = trig_level(ctrl_now.rx_trigger, rx_status_i.sync_mode);
    over_req = rx_count > req_limit;
    over_trig = rx_count > trig_limit;
    flow_allowed = HAS_FLOW_CTRL && ctrl_now.modem_ctrl_enable;
    full_set = over_trig;
    full_clear = rx_status_i.rx_full_clear;
  end

  always_comb begin
    next_state = state;
    next_state.ctrl = next_ctrl;
    // set beats clear, so an arrival during a clear is not lost
    if (full_set) begin
      next_state.rx_full_flag = 1'b1;
    end else if (full_clear) begin
      next_state.rx_full_flag = 1'b0;
    end else begin
      next_state.rx_full_flag = state.rx_full_flag;
    end
    if (flow_allowed) begin
      next_state.flow_req = over_req;
    end else begin
      next_state.flow_req = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state.ctrl <= fifo_control_reg_type'(`FCR_RESET);
      state.rx_full_flag <= 1'b0;
      state.flow_req <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // no read strobe: the register is always visible, so reads cannot stall
  assign reg_rdata_o = state.ctrl;
  assign rx_full_flag_o = state.rx_full_flag;
  assign flow_req_o = state.flow_req;

endmodule : fifo_threshold_ctrl
`default_nettype wire

// ==== fifo_threshold_ctrl_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module fifo_threshold_ctrl_asserts #(
  parameter bit HAS_FLOW_CTRL = 1'b1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire fifo_ctrl_pkg::reg_wr_type reg_wr_i,
  input wire fifo_ctrl_pkg::rx_status_type rx_status_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic rx_full_flag_o,
  input wire logic flow_req_o
);
  localparam logic [15:0] MASK = HAS_FLOW_CTRL ? 16'h07FF : 16'h00F7;
  localparam logic [4:0] RT[8] = '{5'h0F, 5'h01, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E};
  localparam logic [4:0] TG[8] = '{5'h01, 5'h04, 5'h08, 5'h0E, 5'h01, 5'h02, 5'h08, 5'h0E};
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_rst; $fell(srst_i) |-> reg_rdata_o == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_wr; reg_wr_i.wr_en |=> reg_rdata_o == ($past(reg_wr_i.wdata) & MASK); endproperty
  a_wr: assert property (p_wr) else $error("write");
  property p_rsv; reg_rdata_o[15:11] == 5'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_mce; !reg_rdata_o[3] && !reg_wr_i.wr_en |=> !flow_req_o; endproperty
  a_mce: assert property (p_mce) else $error("modem off");
  property p_req; reg_rdata_o[3] && !reg_wr_i.wr_en |=> flow_req_o == ($past(rx_status_i.count) > RT[$past(reg_rdata_o[10:8])]); endproperty
  a_req: assert property (p_req) else $error("flow req");
  sequence s_full_set;
    !reg_wr_i.wr_en && rx_status_i.count > TG[{rx_status_i.sync_mode, reg_rdata_o[7:6]}];
  endsequence
  sequence s_full_clear;
    !reg_wr_i.wr_en && rx_status_i.rx_full_clear && rx_status_i.count <= TG[{rx_status_i.sync_mode, reg_rdata_o[7:6]}];
  endsequence
  property p_full; s_full_set |=> rx_full_flag_o; endproperty
  a_full: assert property (p_full) else $error("rx full");
  property p_clr; s_full_clear |=> !rx_full_flag_o; endproperty
  a_clr: assert property (p_clr) else $error("rx full clear");
  property p_noflow; !HAS_FLOW_CTRL |-> reg_rdata_o[10:8] == 3'h0 && !reg_rdata_o[3] && !flow_req_o; endproperty
  a_noflow: assert property (p_noflow) else $error("third channel");
endmodule : fifo_threshold_ctrl_asserts
bind fifo_threshold_ctrl fifo_threshold_ctrl_asserts #(.HAS_FLOW_CTRL(HAS_FLOW_CTRL)) u_chk (.clk_i, .srst_i,
  .reg_wr_i, .rx_status_i, .reg_rdata_o, .rx_full_flag_o, .flow_req_o);
`default_nettype wire

// ==== rx_peer.sv ====
`timescale 1ns/10ps
`default_nettype none
// remote sender: keeps pushing bytes until the flow request stops it or the count reaches 16
module rx_peer (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic flow_req_i,
  output logic [4:0] count_o
);
  always_ff @(posedge clk_i) begin
    if (clr_i) count_o <= 5'h00;
    else if (!flow_req_i && count_o < 5'h10) count_o <= count_o + 5'h01;
  end
endmodule : rx_peer
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fifo_ctrl_pkg::*;
  logic clk_i = 0, srst_i = 1, clr = 1, sm = 0, fc = 0, full, req, full2, req2;
  reg_wr_type wr = '0;
  logic [15:0] rd, rd2;
  logic [4:0] cnt, e;
  int err_total = 0, checked = 0;
  logic [4:0] th[8] = '{5'h0F, 5'h01, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E};
  logic [4:0] tg[8] = '{5'h01, 5'h04, 5'h08, 5'h0E, 5'h01, 5'h02, 5'h08, 5'h0E};
  always #2.5 clk_i = ~clk_i;
  fifo_threshold_ctrl u_fifo_threshold_ctrl (.clk_i, .srst_i, .reg_wr_i(wr), .rx_status_i({cnt, sm, fc}),
    .reg_rdata_o(rd), .rx_full_flag_o(full), .flow_req_o(req));
  // third channel: no flow-control bits, shares bus and fill count
  fifo_threshold_ctrl #(.HAS_FLOW_CTRL(1'b0)) u_fifo_threshold_ctrl_ch2 (.clk_i, .srst_i, .reg_wr_i(wr),
    .rx_status_i({cnt, sm, fc}), .reg_rdata_o(rd2), .rx_full_flag_o(full2), .flow_req_o(req2));
  rx_peer u_rx_peer (.clk_i, .clr_i(clr), .flow_req_i(req), .count_o(cnt));
  task cmp(string n, logic [15:0] x, logic [15:0] s);
    checked++;
    if (s !== x) begin err_total++; $display("unexpected %s exp %h got %h", n, x, s); end
  endtask : cmp
  task give_verdict;
    $display("checked %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task wr16(logic [15:0] d);
    @(posedge clk_i); #1 wr = {1'b1, d};
    @(posedge clk_i); #1 wr.wr_en = 0;
  endtask : wr16
  task t_thr;
    for (int k = 0; k < 8; k++) begin
      clr = 1; fc = 1; sm = k[2];
      wr16({5'h00, k[2:0], k[1:0], 6'h08});
      cmp("rd", {5'h00, k[2:0], k[1:0], 6'h08}, rd);
      @(posedge clk_i); #1 clr = 0; fc = 0;
      repeat (30) @(posedge clk_i);
      e = (th[k] > 5'h0E) ? 5'h10 : th[k] + 5'h02;
      cmp("count", e, cnt);
      cmp("req", 1, req);
      cmp("full", e > tg[k], full);
      cmp("req2", 0, req2);
      cmp("full2", e > tg[k], full2);
    end
    $display("t_thr done");
  endtask : t_thr
  task t_rst;
    repeat (5) @(posedge clk_i);
    #1 srst_i = 0;
    cmp("rd", 16'h0000, rd);
    cmp("full", 0, full);
    cmp("req", 0, req);
    $display("t_rst done");
  endtask : t_rst
  task t_regs;
    wr16(16'hFFFF);
    cmp("rd", 16'h07FF, rd);
    cmp("rd2", 16'h00F7, rd2);
    $display("t_regs done");
  endtask : t_regs
  task t_clr;
    @(posedge clk_i); #1 fc = 1;
    @(posedge clk_i); #1 fc = 0;
    cmp("full", 1, full);
    clr = 1;
    @(posedge clk_i); #1 fc = 1;
    @(posedge clk_i); #1 fc = 0;
    cmp("full", 0, full);
    $display("t_clr done");
  endtask : t_clr
  task t_mce;
    sm = 0; clr = 1;
    wr16(16'h0100);
    clr = 0;
    repeat (30) @(posedge clk_i);
    cmp("req", 0, req);
    wr16(16'h0108);
    @(posedge clk_i); #1 cmp("req", 1, req);
    $display("t_mce done");
  endtask : t_mce
  task t_mid;
    @(posedge clk_i); #1 srst_i = 1;
    repeat (2) @(posedge clk_i);
    #1 srst_i = 0;
    cmp("rd", 16'h0000, rd);
    cmp("req", 0, req);
    cmp("full", 0, full);
    @(posedge clk_i); #1 cmp("full", 1, full);
    cmp("req", 0, req);
    $display("t_mid done");
  endtask : t_mid
  initial begin
    t_rst;
    t_regs;
    t_thr;
    t_clr;
    t_mce;
    t_mid;
    give_verdict;
  end
  initial begin #5000; err_total++; give_verdict; end
endmodule : tb
`default_nettype wire
